//--- logic/ata_host_pkg.sv
// Shared types and constants for the parallel storage bus host controller.
package ata_host_pkg;

    // Command kinds accepted on the user command port.
    typedef enum logic [1:0] {
        CMD_REG_WRITE,
        CMD_DMA_OUT,
        CMD_DMA_IN
    } cmd_kind_t;

    // One command: kind, register address, and write data or burst word count.
    typedef struct packed {
        cmd_kind_t   kind;
        logic [2:0]  addr;
        logic [15:0] value;
    } cmd_t;

    // Pin group driven by the host towards the device.
    typedef struct packed {
        logic        wr_stop;   // Write strobe in register mode, STOP during a burst.
        logic        rd_rdy;    // Read strobe, host ready or host data strobe.
        logic        dmack_b;
        logic        cs0_b;
        logic [2:0]  addr;
        logic [15:0] data;
        logic        data_oe_b;
    } host_pins_t;

    // Cycle counts on the link clock for the register write strobe.
    localparam logic [3:0]  SETUP_CYC  = 4'h3;
    localparam logic [3:0]  STROBE_CYC = 4'h5;
    localparam logic [3:0]  HOLD_CYC   = 4'h2;

    // Idle pin values after reset.
    localparam host_pins_t  PINS_IDLE  = '{wr_stop: 1'b1, rd_rdy: 1'b1, dmack_b: 1'b1,
                                           cs0_b: 1'b1, addr: 3'h0, data: 16'h0000,
                                           data_oe_b: 1'b1};

    localparam int          FIFO_DEPTH = 16;
    localparam int          DATA_W     = 16;

endpackage

//--- logic/ata_host_ctrl.sv
// Host controller for the parallel storage bus: register writes and UDMA bursts.
`timescale 1ns/1ps

// Word buffer with registered full and empty flags, single clock.
module ata_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // Flags come from the stored count so both handshake sides see registered values.
    always_comb begin
        push    = i_in_valid && (cnt_r != DEPTH_V);
        pop     = i_out_ready && (cnt_r != '0);
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_r        <= '0;
            rp_r        <= '0;
            cnt_r       <= '0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
        end else if (i_ce) begin
            wp_r        <= wp_nxt;
            rp_r        <= rp_nxt;
            cnt_r       <= cnt_nxt;
            o_in_ready  <= cnt_nxt != DEPTH_V;
            o_out_valid <= cnt_nxt != '0;
        end
    end

    // Storage has no reset; the read port shows the head entry.
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wp_r] <= i_in_data;
        end
    end
    assign o_out_data = mem[rp_r];
endmodule

module ata_host_ctrl
    import ata_host_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic        i_link_clk,
    input  wire cmd_t        i_cmd,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic [15:0] i_tx_data,
    input  wire logic        i_tx_valid,
    output logic             o_tx_ready,
    output logic      [15:0] o_rx_data,
    output logic             o_rx_valid,
    input  wire logic        i_rx_ready,
    input  wire logic        i_dev_reset,
    output logic             o_irq,
    output logic             o_dev_rst_b,
    output host_pins_t       o_pins,
    input  wire logic [15:0] i_pin_data,
    input  wire logic        i_pin_rdy_strobe,
    input  wire logic        i_pin_dmarq,
    input  wire logic        i_pin_intrq
);
    typedef enum {L_IDLE, L_PSETUP, L_PSTROBE, L_PHOLD, L_DREQ, L_DOUT, L_DIN,
                  L_STOP, L_DONE} lstate_t;

    // Link-domain state comes first because the core side reads its toggles.
    lstate_t     st_r, st_nxt;
    logic        lr1_r, lrst_b;
    logic [1:0]  ce_s, ctg_s, wtg_s, rxr_s, rq_s;
    logic [2:0]  rdy_s;
    logic [15:0] dd1_r, dd_s;
    logic        lack_r, lack_nxt, lwack_r, lwack_nxt, rxtgl_r, rxtgl_nxt;
    logic [15:0] rxw_r, rxw_nxt, cnt16_r, cnt16_nxt;
    logic [3:0]  tm_r, tm_nxt;
    logic        ph_r, ph_nxt;
    host_pins_t  pins_nxt;

    // Core-domain state.
    logic        rs1_r, rst_b;
    logic        irq1_r, irq2_r;
    logic [1:0]  cack_r, wack_r;
    logic [2:0]  rxt_r;
    logic        ctgl_r, ctgl_nxt, wtgl_r, wtgl_nxt, busy_nxt, rxv_nxt;
    cmd_t        cmd_r, cmd_nxt;
    logic [15:0] word_r, word_nxt, rxd_nxt;
    logic [15:0] f_data;
    logic        f_valid, f_pop;

    // Reset release through two flip-flops; assertion stays asynchronous.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rs1_r <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_b <= rs1_r;
        end
    end

    ata_word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (rst_b),
        .i_ce        (i_ce),
        .i_in_data   (i_tx_data),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .o_out_data  (f_data),
        .o_out_valid (f_valid),
        .i_out_ready (f_pop)
    );

    // Command and word toggles; a new word crosses only once the last one was taken.
    always_comb begin
        ctgl_nxt = ctgl_r;
        cmd_nxt  = cmd_r;
        busy_nxt = !o_cmd_ready && (cack_r[1] != ctgl_r);
        if (o_cmd_ready && i_cmd_valid) begin
            ctgl_nxt = !ctgl_r;
            cmd_nxt  = i_cmd;
            busy_nxt = 1'b1;
        end
        f_pop    = f_valid && (wack_r[1] == wtgl_r);
        wtgl_nxt = f_pop ? !wtgl_r : wtgl_r;
        word_nxt = f_pop ? f_data : word_r;
        rxv_nxt  = rxt_r[2] != rxt_r[1];
        rxd_nxt  = rxv_nxt ? rxw_r : o_rx_data;
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctgl_r      <= 1'b0;
            wtgl_r      <= 1'b0;
            cmd_r       <= '0;
            word_r      <= 16'h0000;
            cack_r      <= 2'h0;
            wack_r      <= 2'h0;
            rxt_r       <= 3'h0;
            irq1_r      <= 1'b0;
            irq2_r      <= 1'b0;
            o_irq       <= 1'b0;
            o_cmd_ready <= 1'b0;
            o_rx_valid  <= 1'b0;
            o_rx_data   <= 16'h0000;
            o_dev_rst_b <= 1'b0;
        end else if (i_ce) begin
            ctgl_r      <= ctgl_nxt;
            wtgl_r      <= wtgl_nxt;
            cmd_r       <= cmd_nxt;
            word_r      <= word_nxt;
            cack_r      <= {cack_r[0], lack_r};
            wack_r      <= {wack_r[0], lwack_r};
            rxt_r       <= {rxt_r[1:0], rxtgl_r};
            irq1_r      <= i_pin_intrq;
            irq2_r      <= irq1_r;
            o_irq       <= irq2_r;                          // High means pending.
            o_cmd_ready <= !busy_nxt;
            o_rx_valid  <= rxv_nxt && !o_rx_valid;
            o_rx_data   <= rxd_nxt;
            o_dev_rst_b <= !i_dev_reset;                     // Low holds device in reset.
        end
    end

    // Link-domain reset release through two flip-flops of its own.
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lr1_r  <= 1'b0;
            lrst_b <= 1'b0;
        end else begin
            lr1_r  <= 1'b1;
            lrst_b <= lr1_r;
        end
    end

    // Link state machine; command fields are stable while the toggle is unanswered.
    always_comb begin
        st_nxt    = st_r;
        tm_nxt    = (tm_r != 4'h0) ? tm_r - 4'h1 : tm_r;
        ph_nxt    = ph_r;
        cnt16_nxt = cnt16_r;
        lack_nxt  = lack_r;
        lwack_nxt = lwack_r;
        rxtgl_nxt = rxtgl_r;
        rxw_nxt   = rxw_r;
        pins_nxt  = o_pins;
        case (st_r)
            L_IDLE: begin
                pins_nxt = PINS_IDLE;                        // Strobes idle between transfers.
                if (ctg_s[1] != lack_r) begin
                    cnt16_nxt = cmd_r.value;
                    if (cmd_r.kind == CMD_REG_WRITE) begin
                        pins_nxt.addr      = cmd_r.addr;
                        pins_nxt.cs0_b     = 1'b0;
                        pins_nxt.data      = cmd_r.value;
                        pins_nxt.data_oe_b = 1'b0;
                        tm_nxt             = SETUP_CYC;
                        st_nxt             = L_PSETUP;
                    end else begin
                        st_nxt = L_DREQ;
                    end
                end
            end
            L_PSETUP: begin
                if (tm_r == 4'h0) begin
                    pins_nxt.wr_stop = 1'b0;                 // Open the write pulse.
                    tm_nxt           = STROBE_CYC;
                    st_nxt           = L_PSTROBE;
                end
            end
            L_PSTROBE: begin
                if (tm_r == 4'h0 && rdy_s[1]) begin          // Device ready stretches the cycle.
                    pins_nxt.wr_stop = 1'b1;                 // Rising edge latches the data.
                    tm_nxt           = HOLD_CYC;
                    st_nxt           = L_PHOLD;
                end
            end
            L_PHOLD: begin
                if (tm_r == 4'h0) begin
                    st_nxt = L_DONE;
                end
            end
            L_DREQ: begin
                if (rq_s[1]) begin                           // Wait for the device request.
                    pins_nxt.dmack_b = 1'b0;                 // Acknowledge the request.
                    pins_nxt.wr_stop = 1'b0;
                    ph_nxt           = 1'b0;
                    if (cnt16_r == 16'h0000) begin
                        st_nxt = L_STOP;
                    end else if (cmd_r.kind == CMD_DMA_OUT) begin
                        pins_nxt.data_oe_b = 1'b0;
                        st_nxt             = L_DOUT;
                    end else begin
                        st_nxt = L_DIN;
                    end
                end
            end
            L_DOUT: begin
                // Phase 0 puts a word out, phase 1 flips the strobe one cycle later.
                if (!ph_r) begin
                    if (!rdy_s[1] && wtg_s[1] != lwack_r) begin  // Only while device ready.
                        pins_nxt.data = word_r;
                        lwack_nxt     = !lwack_r;
                        ph_nxt        = 1'b1;
                    end
                end else begin
                    pins_nxt.rd_rdy = !o_pins.rd_rdy;        // Each edge moves a word.
                    ph_nxt          = 1'b0;
                    cnt16_nxt       = cnt16_r - 16'h0001;
                    if (cnt16_r == 16'h0001) begin
                        st_nxt = L_STOP;
                    end
                end
            end
            L_DIN: begin
                pins_nxt.rd_rdy = !rxr_s[1];                 // Raise ready to pause the device.
                if (rdy_s[2] != rdy_s[1]) begin              // Device strobe edge, either way.
                    rxw_nxt   = dd_s;
                    rxtgl_nxt = !rxtgl_r;
                    cnt16_nxt = cnt16_r - 16'h0001;
                    if (cnt16_r == 16'h0001) begin
                        st_nxt = L_STOP;
                    end
                end
            end
            L_STOP: begin
                pins_nxt.wr_stop   = 1'b1;                   // STOP ends the burst.
                pins_nxt.data_oe_b = 1'b1;
                pins_nxt.rd_rdy    = 1'b1;
                if (!rq_s[1]) begin
                    pins_nxt.dmack_b = 1'b1;
                    st_nxt           = L_DONE;
                end
            end
            L_DONE: begin
                pins_nxt = PINS_IDLE;
                lack_nxt = ctg_s[1];
                st_nxt   = L_IDLE;
            end
            default: begin
                st_nxt = L_IDLE;
            end
        endcase
    end

    // Pin and handshake inputs pass two flip-flops; the data bus is synchronised
    // alongside the strobe so the captured word lines up with the detected edge.
    always_ff @(posedge i_link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            ce_s  <= 2'h0;
            ctg_s <= 2'h0;
            wtg_s <= 2'h0;
            rxr_s <= 2'h0;
            rq_s  <= 2'h0;
            rdy_s <= 3'h0;
            dd1_r <= 16'h0000;
            dd_s  <= 16'h0000;
        end else begin
            ce_s  <= {ce_s[0], i_ce};
            if (ce_s[1]) begin
                ctg_s <= {ctg_s[0], ctgl_r};
                wtg_s <= {wtg_s[0], wtgl_r};
                rxr_s <= {rxr_s[0], i_rx_ready};
                rq_s  <= {rq_s[0], i_pin_dmarq};
                rdy_s <= {rdy_s[1:0], i_pin_rdy_strobe};
                dd1_r <= i_pin_data;
                dd_s  <= dd1_r;
            end
        end
    end

    always_ff @(posedge i_link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            st_r    <= L_IDLE;
            tm_r    <= 4'h0;
            ph_r    <= 1'b0;
            cnt16_r <= 16'h0000;
            lack_r  <= 1'b0;
            lwack_r <= 1'b0;
            rxtgl_r <= 1'b0;
            rxw_r   <= 16'h0000;
            o_pins  <= PINS_IDLE;
        end else if (ce_s[1]) begin
            st_r    <= st_nxt;
            tm_r    <= tm_nxt;
            ph_r    <= ph_nxt;
            cnt16_r <= cnt16_nxt;
            lack_r  <= lack_nxt;
            lwack_r <= lwack_nxt;
            rxtgl_r <= rxtgl_nxt;
            rxw_r   <= rxw_nxt;
            o_pins  <= pins_nxt;
        end
    end
endmodule

//--- testbench/ata_host_ctrl_sva.sv
// Port-level checks for the storage bus host controller.
`timescale 1ns/1ps

module ata_host_ctrl_sva
    import ata_host_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_link_clk,
    input wire logic       i_dev_reset,
    input wire logic       o_dev_rst_b,
    input wire logic       o_irq,
    input wire logic       i_pin_intrq,
    input wire logic       i_pin_dmarq,
    input wire host_pins_t o_pins
);
    // Core-side relays of the device reset and interrupt.
    property p_dev_rst;
        @(posedge i_clk) disable iff (!i_rst_b) i_dev_reset |=> !o_dev_rst_b;
    endproperty
    a_dev_rst: assert property (p_dev_rst) else $error("reset pin not low");
    property p_irq;
        @(posedge i_clk) disable iff (!i_rst_b) i_pin_intrq [*8] |-> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not relayed");
    // Link-side pin sequencing.
    property p_dmack;
        @(posedge i_link_clk) disable iff (!i_rst_b) $fell(o_pins.dmack_b) |-> $past(i_pin_dmarq);
    endproperty
    a_dmack: assert property (p_dmack) else $error("ack without request");
    property p_idle;
        @(posedge i_link_clk) disable iff (!i_rst_b)
            o_pins.dmack_b && o_pins.cs0_b |-> o_pins.wr_stop && o_pins.rd_rdy && o_pins.data_oe_b;
    endproperty
    a_idle: assert property (p_idle) else $error("strobe active while idle");
    property p_wr_pulse;
        @(posedge i_link_clk) disable iff (!i_rst_b)
            $fell(o_pins.wr_stop) && o_pins.dmack_b |-> (!o_pins.wr_stop) [*5];
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe short");
    property p_wr_setup;
        @(posedge i_link_clk) disable iff (!i_rst_b)
            $fell(o_pins.wr_stop) && o_pins.dmack_b |-> $past(o_pins.cs0_b, 2) == 1'b0;
    endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("write setup short");
    property p_stop;
        @(posedge i_link_clk) disable iff (!i_rst_b)
            $rose(o_pins.wr_stop) && !o_pins.dmack_b |=> o_pins.wr_stop [*2];
    endproperty
    a_stop: assert property (p_stop) else $error("stop not held");
    property p_hstrobe;
        @(posedge i_link_clk) disable iff (!i_rst_b)
            !o_pins.dmack_b && !o_pins.data_oe_b && !o_pins.wr_stop && $changed(o_pins.rd_rdy)
            |-> $stable(o_pins.data);
    endproperty
    a_hstrobe: assert property (p_hstrobe) else $error("data moved on strobe");
    c_wr: cover property (@(posedge i_link_clk) $rose(o_pins.wr_stop) && o_pins.dmack_b);
    c_stop: cover property (@(posedge i_link_clk) $rose(o_pins.wr_stop) && !o_pins.dmack_b);
    c_irq: cover property (@(posedge i_clk) $rose(o_irq));
endmodule

//--- testbench/ata_dev_model.sv
// Behavioural storage device answering on the host pins.
`timescale 1ns/1ps

module ata_dev_model
    import ata_host_pkg::*;
(
    input  wire logic       i_clk,
    input  wire host_pins_t i_pins,
    output logic     [15:0] o_data,
    output logic            o_rdy_strobe,
    output logic            o_dmarq,
    output logic            o_intrq
);
    logic [15:0] regs [8];
    logic [15:0] got_q [$];
    logic [15:0] send_q [$];
    logic        dir_out   = 1'b0;
    logic        irq_req   = 1'b0;
    logic        prev_wr   = 1'b1;
    logic        prev_rd   = 1'b1;
    int          stall_cyc = 0;
    int          stall     = 0;
    int          pause_at  = -1;
    int          pause     = 0;
    int          phase     = 0;

    initial begin
        o_data = 16'h0000;
        o_rdy_strobe = 1'b1;
        o_dmarq = 1'b0;
    end
    assign o_intrq = irq_req;

    // Request is raised here and only the acknowledged burst's STOP drops it.
    task automatic start_dma(input logic out);
        dir_out = out;
        o_dmarq <= 1'b1;
    endtask

    // Pin behaviour, sampled on the link clock as the host drives it.
    // Outputs driven in this block move by non-blocking assignment so the host never races the model.
    always @(posedge i_clk) begin
        if (!prev_wr && i_pins.wr_stop && !i_pins.cs0_b && i_pins.dmack_b)
            regs[i_pins.addr] = i_pins.data;
        if (prev_wr && !i_pins.wr_stop && i_pins.dmack_b)
            stall = stall_cyc;
        else if (stall > 0)
            stall--;
        if (!i_pins.dmack_b && i_pins.wr_stop)
            o_dmarq <= 1'b0;
        if (i_pins.dmack_b) begin
            o_rdy_strobe <= (stall == 0);
            o_data <= ~o_data; // A released bus must not keep its last value.
            phase = 0;
        end else if (dir_out) begin
            if (!i_pins.wr_stop && i_pins.rd_rdy != prev_rd) begin
                got_q.push_back(i_pins.data);
                if (got_q.size() == pause_at) pause = 12;
            end
            if (pause > 0) pause--;
            o_rdy_strobe <= (pause > 0);
            o_data <= ~o_data;
        end else if (!i_pins.wr_stop && !i_pins.rd_rdy && send_q.size() > 0) begin
            phase = (phase + 1) % 8; // Data leads the strobe edge by three cycles.
            if (phase == 1) o_data <= send_q[0];
            if (phase == 4) begin
                void'(send_q.pop_front());
                o_rdy_strobe <= ~o_rdy_strobe;
            end
        end
        prev_wr = i_pins.wr_stop;
        prev_rd = i_pins.rd_rdy;
    end
endmodule

//--- testbench/ata_host_ctrl_tb_top.sv
// Self-checking bench for the storage bus host controller.
`timescale 1ns/1ps

module ata_host_ctrl_tb_top
    import ata_host_pkg::*;
();
    logic        clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0;
    cmd_t        cmd = '0;
    logic        cmd_valid = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1, dev_reset = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    logic        cmd_ready, tx_ready, rx_valid, irq, dev_rst_b, rdy_strobe, dmarq, intrq;
    logic [15:0] rx_data, pin_data;
    host_pins_t  pins;
    logic [15:0] rx_q [$];
    int          bad_count = 0;
    int          n_checks = 0;

    // Free-running clocks of unrelated period.
    always #4 clk = ~clk;
    always #3 link_clk = ~link_clk;

    ata_host_ctrl #(.DEPTH(FIFO_DEPTH)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1),
        .i_link_clk(link_clk), .i_cmd(cmd), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
        .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_dev_reset(dev_reset), .o_irq(irq),
        .o_dev_rst_b(dev_rst_b), .o_pins(pins), .i_pin_data(pin_data),
        .i_pin_rdy_strobe(rdy_strobe), .i_pin_dmarq(dmarq), .i_pin_intrq(intrq));
    ata_dev_model dev (.i_clk(link_clk), .i_pins(pins), .o_data(pin_data),
        .o_rdy_strobe(rdy_strobe), .o_dmarq(dmarq), .o_intrq(intrq));

    // Received words are single-cycle pulses, so collect them as they pass.
    // Sampled at the falling edge, where the registered pulse has settled.
    always @(negedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send_cmd(input cmd_kind_t k, input logic [2:0] a, input logic [15:0] v,
                            output int busy);
        @(negedge clk);
        cmd = '{kind: k, addr: a, value: v};
        cmd_valid = 1'b1;
        for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        for (busy = 0; busy < 4 && cmd_ready === 1'b1; busy++) @(negedge clk);
        for (busy = 0; busy < 5000 && cmd_ready !== 1'b1; busy++) @(negedge clk);
        chk({15'h0, cmd_ready}, 16'h0001);
    endtask

    task automatic t_reg_write();
        int b0, b1;
        send_cmd(CMD_REG_WRITE, 3'h1, 16'h5A3C, b0);
        chk(dev.regs[1], 16'h5A3C);
        dev.stall_cyc = 40;
        send_cmd(CMD_REG_WRITE, 3'h7, 16'hC3A5, b1);
        chk(dev.regs[7], 16'hC3A5);
        chk({15'h0, b1 > b0 + 20}, 16'h0001);
    endtask

    task automatic t_dma_out();
        int n, b;
        n = 0;
        @(negedge clk);
        tx_valid = 1'b1;
        // Exactly one burst's worth is queued; ready is read where it has settled.
        for (int i = 0; i < 40 && n < 16; i++) begin
            tx_data = 16'hD000 + n[15:0];
            if (tx_ready === 1'b1) n++;
            @(negedge clk);
        end
        tx_valid = 1'b0;
        chk(n[15:0], 16'h0010);
        dev.pause_at = 5;
        dev.start_dma(1'b1);
        send_cmd(CMD_DMA_OUT, 3'h0, 16'h0010, b);
        chk({15'h0, dmarq}, 16'h0000);
        chk(16'(dev.got_q.size()), 16'h0010);
        for (int i = 0; i < 16; i++) chk(dev.got_q[i], 16'hD000 + i[15:0]);
    endtask

    task automatic t_dma_in();
        int b, k;
        for (int i = 0; i < 6; i++) dev.send_q.push_back(16'h3E00 + i[15:0]);
        dev.start_dma(1'b0);
        fork
            send_cmd(CMD_DMA_IN, 3'h0, 16'h0006, b);
            begin
                for (int i = 0; i < 3000 && rx_q.size() < 2; i++) @(negedge clk);
                rx_ready = 1'b0;
                repeat (20) @(negedge clk);
                k = rx_q.size();
                repeat (40) @(negedge clk);
                chk(16'(rx_q.size()), k[15:0]);
                rx_ready = 1'b1;
            end
        join
        chk(16'(rx_q.size()), 16'h0006);
        for (int i = 0; i < 6; i++) chk(rx_q[i], 16'h3E00 + i[15:0]);
    endtask

    task automatic t_irq_reset();
        dev.irq_req = 1'b1;
        repeat (8) @(negedge clk);
        chk({15'h0, irq}, 16'h0001);
        dev.irq_req = 1'b0;
        dev_reset = 1'b1;
        repeat (8) @(negedge clk);
        chk({15'h0, irq}, 16'h0000);
        chk({15'h0, dev_rst_b}, 16'h0000);
        dev_reset = 1'b0;
        repeat (3) @(negedge clk);
        chk({15'h0, dev_rst_b}, 16'h0001);
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence after a five-cycle reset.
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        t_reg_write();
        t_dma_out();
        t_dma_in();
        t_irq_reset();
        stop_test();
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule

bind ata_host_ctrl ata_host_ctrl_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_link_clk(i_link_clk), .i_dev_reset(i_dev_reset), .o_dev_rst_b(o_dev_rst_b),
    .o_irq(o_irq), .i_pin_intrq(i_pin_intrq), .i_pin_dmarq(i_pin_dmarq), .o_pins(o_pins));
